// ### dv/startup_regs_chk.sv
// Assertion checker for the start-up register bank.
// Assumes one clock domain; bound onto the top module below.
`timescale 1ns/100ps
module startup_regs_chk import startup_regs_pkg::*; (
  input wire logic              I_CLK, I_RST_N, I_CE, I_ENTER_INIT,
  input wire logic              I_FROM_LOW_POWER_STANDBY_STATE, I_RAIL_EN, O_RVALID,
  input wire logic              O_ADDR_ERR, O_SOFT_REBOOT, O_CONF_RELOAD,
  input wire reg_req_s          I_REQ,
  input wire logic [DATA_W-1:0] O_RDATA,
  input wire boot_cfg_s         O_CFG
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  wire wr_ctl = I_CE && I_REQ.wr_en && I_REQ.addr == STARTUP_CONTROL_OFS;

  a_reboot_start: assert property (I_CE && I_REQ.wr_en && I_REQ.wdata[0]
    && I_REQ.addr == REBOOT_REQUEST_OFS |=> O_SOFT_REBOOT) else $error("no reboot");
  a_reboot_clear: assert property (O_SOFT_REBOOT && I_CE && !I_REQ.wr_en
    |=> !O_SOFT_REBOOT) else $error("reboot stuck");
  a_reload_cause: assert property ($rose(O_CONF_RELOAD)
    |-> $past(I_CE && I_ENTER_INIT)) else $error("stray reload");
  a_target_mcu: assert property (wr_ctl && I_REQ.wdata[6:5] == TARGET_MCU_ONLY
    |=> O_CFG.boot_target == DEST_MCU_ONLY) else $error("bad target");
  a_selftest_sel: assert property (wr_ctl |=> O_CFG.analog_bist_en &&
    O_CFG.logic_bist_en == !$past(I_REQ.wdata[4])) else $error("bad bist");
  a_standby_sel: assert property (wr_ctl |=>
    O_CFG.low_power_standby == $past(I_REQ.wdata[3])) else $error("bad standby");
  a_read_answer: assert property (I_CE && I_REQ.rd_en |=> O_RVALID)
    else $error("no read answer");
  a_rail_clear: assert property (I_CE && !I_RAIL_EN ##1 I_CE && I_REQ.rd_en
    && I_REQ.addr == SPARE_STORAGE_1_OFS |=> O_RDATA == 8'h00) else $error("kept");
endmodule // startup_regs_chk

bind startup_regs startup_regs_chk u_chk (.*);

// ### dv/tb_startup_regs.sv
// Self-checking bench for the start-up register bank.
// Assumes the checker is bound in by its own file.
`timescale 1ns/100ps
module tb_startup_regs;
  import startup_regs_pkg::*;
  logic I_CLK = 0, I_RST_N = 0, I_CE = 1, I_ENTER_INIT = 0;
  logic I_FROM_LOW_POWER_STANDBY_STATE = 0, I_RAIL_EN = 1, O_RVALID, O_ADDR_ERR;
  logic O_SOFT_REBOOT, O_CONF_RELOAD;
  reg_req_s I_REQ = '0;
  logic [DATA_W-1:0] O_RDATA, d, q[$];
  boot_cfg_s O_CFG;
  int num_errors = 0, num_checks = 0, cyc = 0, reb = 0, rel = 0, aer = 0;
  startup_regs u_dut (.*);
  initial forever #2 I_CLK = ~I_CLK;
  task automatic chk(string n, logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, v);
    @(posedge I_CLK);
    I_REQ <= '{w, !w, a, v};
    @(posedge I_CLK);
    I_REQ <= '0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, e);
    q.push_back(e);
    acc(0, a, 8'h00);
  endtask
  task automatic boot(logic lp, int e);
    int r0;
    r0 = rel;
    @(posedge I_CLK);
    I_ENTER_INIT <= 1;
    I_FROM_LOW_POWER_STANDBY_STATE <= lp;
    @(posedge I_CLK);
    I_ENTER_INIT <= 0;
    repeat (2) @(posedge I_CLK);
    chk("reload", 8'(rel - r0), 8'(e));
  endtask
  function automatic boot_dest_e dest(logic [7:0] v);
    if (v[6:5] == 2'h0) return v[3] ? DEST_LOW_POWER_STANDBY : DEST_STANDBY;
    if (v[6:5] == 2'h1) return DEST_RESERVED;
    return v[5] ? DEST_ACTIVE : DEST_MCU_ONLY;
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Read answers are matched in order against noted expectations
  always @(negedge I_CLK) begin
    cyc++;
    if (O_RVALID === 1'b1) chk("rdata", O_RDATA, q.pop_front());
    reb += int'(O_SOFT_REBOOT === 1'b1);
    rel += int'(O_CONF_RELOAD === 1'b1);
    aer += int'(O_ADDR_ERR === 1'b1);
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(48));
    repeat (5) @(posedge I_CLK);
    I_RST_N <= 1;
    rd(8'hC4, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      rd(8'(SPARE_STORAGE_1_OFS + i), 8'h00);
      acc(1, 8'(SPARE_STORAGE_1_OFS + i), d);
      rd(8'(SPARE_STORAGE_1_OFS + i), d);
    end
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[6:3] = {i[1:0], d[4], i[2]};
      acc(1, STARTUP_CONTROL_OFS, d);
      chk("target", 8'(O_CFG.boot_target), 8'(dest(d)));
      chk("standby", 8'(O_CFG.low_power_standby), 8'(d[3]));
      chk("bist", 8'({O_CFG.logic_bist_en, O_CFG.analog_bist_en}),
          8'({~d[4], 1'b1}));
      rd(STARTUP_CONTROL_OFS, d & 8'hFC);
    end
    d = 8'(reb);
    acc(1, REBOOT_REQUEST_OFS, 8'hFF);
    repeat (3) @(posedge I_CLK);
    chk("reboot", 8'(reb) - d, 8'h01);
    rd(REBOOT_REQUEST_OFS, 8'h00);
    acc(1, STARTUP_CONTROL_OFS, 8'h04);
    boot(1, 0);
    boot(0, 1);
    acc(1, STARTUP_CONTROL_OFS, 8'h80);
    boot(0, 0);
    acc(1, SPARE_STORAGE_1_OFS, 8'h5A);
    @(posedge I_CLK);
    I_RAIL_EN <= 0;
    rd(SPARE_STORAGE_1_OFS, 8'h00);
    I_RAIL_EN <= 1;
    // Enable low must freeze storage
    acc(1, SPARE_STORAGE_2_OFS, 8'hA5);
    I_CE <= 0;
    acc(1, SPARE_STORAGE_2_OFS, 8'h3C);
    I_CE <= 1;
    rd(SPARE_STORAGE_2_OFS, 8'hA5);
    // Mid-run reset clears the bank
    acc(1, SPARE_STORAGE_3_OFS, 8'h77);
    I_RST_N <= 0;
    repeat (2) @(posedge I_CLK);
    I_RST_N <= 1;
    rd(SPARE_STORAGE_3_OFS, 8'h00);
    rd(STARTUP_CONTROL_OFS, 8'h00);
    repeat (3) @(posedge I_CLK);
    chk("addr_err", 8'(aer), 8'h01);
    chk("pending", 8'(q.size()), 8'h00);
    finish_test();
  end
endmodule // tb_startup_regs

// ### hw/startup_regs.sv
// Start-up control, soft reboot request and spare storage registers.
// Assumes a byte register port already decoded from the serial interface
// and a power state machine that reports init entry and rail status.
`timescale 1ns/100ps

module startup_regs (
  // Clock, reset, enable
  input  wire logic                        I_CLK,
  input  wire logic                        I_RST_N,
  input  wire logic                        I_CE,
  // Register port
  input  wire startup_regs_pkg::reg_req_s  I_REQ,
  output logic [startup_regs_pkg::DATA_W-1:0] O_RDATA,
  output logic                             O_RVALID,
  output logic                             O_ADDR_ERR,
  // Power state machine side
  input  wire logic                        I_ENTER_INIT,
  input  wire logic                        I_FROM_LOW_POWER_STANDBY_STATE,
  input  wire logic                        I_RAIL_EN,
  output logic                             O_SOFT_REBOOT,
  output logic                             O_CONF_RELOAD,
  output startup_regs_pkg::boot_cfg_s      O_CFG
);
  import startup_regs_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0]        startup_control;
    logic [2:0][DATA_W-1:0]   spare;
    logic                     reboot_bit;
    logic                     conf_reload;
    logic [DATA_W-1:0]        rdata;
    logic                     rvalid;
    logic                     addr_err;
    boot_cfg_s                cfg;
  } state_s;

  state_s state_reg;
  state_s state_next;

  function automatic boot_dest_e decode_target(input logic [DATA_W-1:0] c);
    boot_dest_e d;
    d = DEST_RESERVED;
    case (c[BOOT_TARGET_HI:BOOT_TARGET_LO])
      TARGET_STANDBY:
        d = c[STANDBY_CHOICE_BIT] ? DEST_LOW_POWER_STANDBY : DEST_STANDBY;
      TARGET_RESERVED: d = DEST_RESERVED;
      TARGET_MCU_ONLY: d = DEST_MCU_ONLY;
      TARGET_ACTIVE:   d = DEST_ACTIVE;
      default:         d = DEST_RESERVED;
    endcase
    return d;
  endfunction

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    return (a == REBOOT_REQUEST_OFS) || (a == STARTUP_CONTROL_OFS) ||
           (a == SPARE_STORAGE_1_OFS) || (a == SPARE_STORAGE_2_OFS) ||
           (a == SPARE_STORAGE_3_OFS);
  endfunction

  always_comb begin
    logic [DATA_W-1:0] ctl;
    ctl = 8'h00;
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.conf_reload = 1'b0;
    state_next.addr_err = 1'b0;
    // Pulse for one cycle, then drop back
    state_next.reboot_bit = 1'b0;

    // Reads return the value before any write in the same cycle
    if (I_REQ.rd_en) begin
      state_next.rvalid = 1'b1;
      state_next.addr_err = ~known_addr(I_REQ.addr);
      case (I_REQ.addr)
        REBOOT_REQUEST_OFS:
          state_next.rdata = {7'h00, state_reg.reboot_bit};
        STARTUP_CONTROL_OFS: state_next.rdata = state_reg.startup_control;
        SPARE_STORAGE_1_OFS: state_next.rdata = state_reg.spare[0];
        SPARE_STORAGE_2_OFS: state_next.rdata = state_reg.spare[1];
        SPARE_STORAGE_3_OFS: state_next.rdata = state_reg.spare[2];
        default:             state_next.rdata = 8'h00;
      endcase
    end

    if (I_REQ.wr_en) begin
      if (!known_addr(I_REQ.addr)) begin
        state_next.addr_err = 1'b1;
      end
      case (I_REQ.addr)
        REBOOT_REQUEST_OFS:
          state_next.reboot_bit = I_REQ.wdata[REBOOT_REQUEST_BIT];
        STARTUP_CONTROL_OFS:
          state_next.startup_control =
            I_REQ.wdata & STARTUP_CONTROL_MASK;
        SPARE_STORAGE_1_OFS: state_next.spare[0] = I_REQ.wdata;
        SPARE_STORAGE_2_OFS: state_next.spare[1] = I_REQ.wdata;
        SPARE_STORAGE_3_OFS: state_next.spare[2] = I_REQ.wdata;
        default: ;
      endcase
    end

    // Rail off wins over a write: storage has no supply to hold it
    if (!I_RAIL_EN) begin
      for (int i = 0; i < 3; i++) begin
        state_next.spare[i] = SPARE_STORAGE_RST;
      end
    end

    if (I_ENTER_INIT) begin
      if (I_FROM_LOW_POWER_STANDBY_STATE && state_reg.startup_control[BYPASS_RELOAD_BIT])
      begin
        state_next.conf_reload = 1'b0;
      end else begin
        state_next.conf_reload =
          ~state_reg.startup_control[INITIAL_BOOT_COMPLETE_BIT];
      end
    end

    ctl = state_next.startup_control;
    state_next.cfg.boot_target = decode_target(ctl);
    state_next.cfg.low_power_standby = ctl[STANDBY_CHOICE_BIT];
    state_next.cfg.logic_bist_en = ~ctl[QUICK_SELFTEST_BIT];
    state_next.cfg.analog_bist_en = 1'b1;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_reg.startup_control <= STARTUP_CONTROL_RST;
      state_reg.spare <= '0;
      state_reg.reboot_bit <= 1'b0;
      state_reg.conf_reload <= 1'b0;
      state_reg.rdata <= 8'h00;
      state_reg.rvalid <= 1'b0;
      state_reg.addr_err <= 1'b0;
      state_reg.cfg.boot_target <= DEST_STANDBY;
      state_reg.cfg.low_power_standby <= 1'b0;
      state_reg.cfg.logic_bist_en <= 1'b1;
      state_reg.cfg.analog_bist_en <= 1'b1;
    end else if (I_CE) begin
      state_reg <= state_next;
    end
  end

  assign O_RDATA = state_reg.rdata;
  assign O_RVALID = state_reg.rvalid;
  assign O_ADDR_ERR = state_reg.addr_err;
  assign O_SOFT_REBOOT = state_reg.reboot_bit;
  assign O_CONF_RELOAD = state_reg.conf_reload;
  assign O_CFG = state_reg.cfg;

endmodule // startup_regs

// ### inc/startup_regs_pkg.sv
// Constants and carrier types for the start-up and reboot register bank.
// Assumes a byte-wide register port from the serial control front end.
package startup_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] REBOOT_REQUEST_OFS = 8'hAB;
  localparam logic [ADDR_W-1:0] STARTUP_CONTROL_OFS = 8'hC3;
  localparam logic [ADDR_W-1:0] SPARE_STORAGE_1_OFS = 8'hC9;
  localparam logic [ADDR_W-1:0] SPARE_STORAGE_2_OFS = 8'hCA;
  localparam logic [ADDR_W-1:0] SPARE_STORAGE_3_OFS = 8'hCB;

  // Reset values
  localparam logic [DATA_W-1:0] STARTUP_CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] SPARE_STORAGE_RST = 8'h00;

  // Field positions in the startup control register
  localparam int INITIAL_BOOT_COMPLETE_BIT = 7;
  localparam int BOOT_TARGET_HI = 6;
  localparam int BOOT_TARGET_LO = 5;
  localparam int QUICK_SELFTEST_BIT = 4;
  localparam int STANDBY_CHOICE_BIT = 3;
  localparam int BYPASS_RELOAD_BIT = 2;
  localparam logic [DATA_W-1:0] STARTUP_CONTROL_MASK = 8'hFC;

  // Field position in the reboot request register
  localparam int REBOOT_REQUEST_BIT = 0;

  // Boot target field encodings
  localparam logic [1:0] TARGET_STANDBY = 2'h0;
  localparam logic [1:0] TARGET_RESERVED = 2'h1;
  localparam logic [1:0] TARGET_MCU_ONLY = 2'h2;
  localparam logic [1:0] TARGET_ACTIVE = 2'h3;

  typedef enum logic [2:0] {
    DEST_STANDBY,
    DEST_LOW_POWER_STANDBY,
    DEST_RESERVED,
    DEST_MCU_ONLY,
    DEST_ACTIVE
  } boot_dest_e;

  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    boot_dest_e boot_target;
    logic       low_power_standby;
    logic       logic_bist_en;
    logic       analog_bist_en;
  } boot_cfg_s;

endpackage
